// File: adc_mode_range_config.sv
// Configuration bank: operating mode and input spans of channels 1 to 6.
// Assumes a synchronous register port with read data one cycle after the strobe.
//
// Overview of operation
// - Mode field bits 1:0: normal/standby/auto/shutdown
// - Configuration register at 0x02, resets 0x00
// - Span register 0x03: channel 2 high, 1 low
// - Span register 0x04: channel 4 high, 3 low
// - Span register 0x05: channel 6 high, 5 low
// - Span codes 0 to 3 select 2.5/5/10/12.5 V
// - Every span field resets to code 2
`timescale 1ns/1ps
module adc_mode_range_config
    import acq_cfg_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               nrst,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [DATA_W-1:0]  reg_rdata,
    output op_mode_t                op_mode,
    output logic                    mode_normal,
    output logic                    mode_standby,
    output logic                    mode_auto_standby,
    output logic                    mode_shutdown,
    output logic                    status_header_en,
    output logic                    ext_os_clk_en,
    output logic      [1:0]         dout_lanes,
    output logic      [3:0]         input_span_1,
    output logic      [3:0]         input_span_2,
    output logic      [3:0]         input_span_3,
    output logic      [3:0]         input_span_4,
    output logic      [3:0]         input_span_5,
    output logic      [3:0]         input_span_6,
    output span_t                   span_kind_1,
    output span_t                   span_kind_2,
    output span_t                   span_kind_3,
    output span_t                   span_kind_4,
    output span_t                   span_kind_5,
    output span_t                   span_kind_6,
    output logic      [NUM_CH-1:0]  span_reserved
);

    // ********************************
    // Address decode
    // ********************************
    logic       wr_cfg;
    logic       wr_12;
    logic       wr_34;
    logic       wr_56;
    logic [7:0] cfg_q;
    logic [7:0] pair_12_q;
    logic [7:0] pair_34_q;
    logic [7:0] pair_56_q;
    logic [7:0] rdata_d;
    span_t      kind_q [NUM_CH];

    always_comb begin
        wr_cfg = 1'b0;
        wr_12  = 1'b0;
        wr_34  = 1'b0;
        wr_56  = 1'b0;
        if (reg_wr && reg_addr == ADDR_CONFIG) begin
            wr_cfg = 1'b1;
        end else if (reg_wr && reg_addr == ADDR_SPAN_12) begin
            wr_12 = 1'b1;
        end else if (reg_wr && reg_addr == ADDR_SPAN_34) begin
            wr_34 = 1'b1;
        end else if (reg_wr && reg_addr == ADDR_SPAN_56) begin
            wr_56 = 1'b1;
        end
    end

    // ********************************
    // Configuration register
    // ********************************
    // mode field decode
    config_reg u_config (
        .ref_clk        (ref_clk),
        .nrst           (nrst),
        .wr_en          (wr_cfg),
        .wdata          (reg_wdata),
        .cfg_q          (cfg_q),
        .mode_q         (op_mode),
        .normal_q       (mode_normal),
        .standby_q      (mode_standby),
        .auto_standby_q (mode_auto_standby),
        .shutdown_q     (mode_shutdown)
    );

    assign status_header_en = cfg_q[HEADER_BIT];
    assign ext_os_clk_en    = cfg_q[EXT_OS_BIT];
    assign dout_lanes       = cfg_q[DOUT_LSB +: 2];

    // ********************************
    // Span registers
    // ********************************
    // channels 1 and 2
    // pair resets to two code-2 fields
    span_pair_reg #(.RST_VAL(SPAN_PAIR_RST)) u_span_12 (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .wr_en     (wr_12),
        .wdata     (reg_wdata),
        .pair_q    (pair_12_q),
        .lo_kind_q (kind_q[0]),
        .hi_kind_q (kind_q[1])
    );

    span_pair_reg #(.RST_VAL(SPAN_PAIR_RST)) u_span_34 (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .wr_en     (wr_34),
        .wdata     (reg_wdata),
        .pair_q    (pair_34_q),
        .lo_kind_q (kind_q[2]),
        .hi_kind_q (kind_q[3])
    );

    span_pair_reg #(.RST_VAL(SPAN_PAIR_RST)) u_span_56 (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .wr_en     (wr_56),
        .wdata     (reg_wdata),
        .pair_q    (pair_56_q),
        .lo_kind_q (kind_q[4]),
        .hi_kind_q (kind_q[5])
    );

    assign input_span_1 = pair_12_q[SPAN_LO_LSB +: 4];
    assign input_span_2 = pair_12_q[SPAN_HI_LSB +: 4];
    assign input_span_3 = pair_34_q[SPAN_LO_LSB +: 4];
    assign input_span_4 = pair_34_q[SPAN_HI_LSB +: 4];
    assign input_span_5 = pair_56_q[SPAN_LO_LSB +: 4];
    assign input_span_6 = pair_56_q[SPAN_HI_LSB +: 4];
    assign span_kind_1  = kind_q[0];
    assign span_kind_2  = kind_q[1];
    assign span_kind_3  = kind_q[2];
    assign span_kind_4  = kind_q[3];
    assign span_kind_5  = kind_q[4];
    assign span_kind_6  = kind_q[5];

    // reserved codes are stored but flagged
    // reserved flag from the written code
    logic [2:0] wr_pair;

    assign wr_pair = {wr_56, wr_34, wr_12};

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_rsvd
            logic rsvd_q;

            // Flag moves on the write edge, as the stored code does; code 2 is not reserved
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    rsvd_q <= 1'b0;
                end else if (wr_pair[ch / 2]) begin
                    rsvd_q <= (span_decode(reg_wdata[(ch % 2) * 4 +: 4]) == SPAN_RESERVED);
                end
            end

            assign span_reserved[ch] = rsvd_q;
        end
    endgenerate

    // ********************************
    // Read port
    // ********************************
    // Unmapped addresses read zero; data stands one cycle only
    always_comb begin
        rdata_d = RDATA_IDLE;
        if (!reg_rd) begin
            rdata_d = RDATA_IDLE;
        end else if (reg_addr == ADDR_CONFIG) begin
            rdata_d = cfg_q;
        end else if (reg_addr == ADDR_SPAN_12) begin
            rdata_d = pair_12_q;
        end else if (reg_addr == ADDR_SPAN_34) begin
            rdata_d = pair_34_q;
        end else if (reg_addr == ADDR_SPAN_56) begin
            rdata_d = pair_56_q;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= RDATA_IDLE;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic cfg_written_q;
    logic span_written_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_written_q  <= 1'b0;
            span_written_q <= 1'b0;
        end else begin
            cfg_written_q  <= cfg_written_q | wr_cfg;
            span_written_q <= span_written_q | wr_12 | wr_34 | wr_56;
        end
    end

    sequence s_cfg_write;
        reg_wr && reg_addr == ADDR_CONFIG;
    endsequence

    sequence s_cfg_read;
        reg_rd && reg_addr == ADDR_CONFIG;
    endsequence

    sequence s_ch1_write_code(logic [3:0] code);
        reg_wr && reg_addr == ADDR_SPAN_12 && reg_wdata[3:0] == code;
    endsequence

    a_mode_field_write: assert property (
        s_cfg_write |=> op_mode == op_mode_t'($past(reg_wdata[1:0])))
        else $error("mode field did not take written value");

    a_mode_flag_match: assert property (
        (mode_shutdown == (op_mode == MODE_SHUTDOWN))
        && (mode_auto_standby == (op_mode == MODE_AUTO_STANDBY))
        && (mode_standby == (op_mode == MODE_STANDBY))
        && (mode_normal == (op_mode == MODE_NORMAL)))
        else $error("mode flags disagree with mode field");

    a_config_reset_val: assert property (
        !cfg_written_q |-> cfg_q == CONFIG_RST && op_mode == MODE_NORMAL)
        else $error("configuration left reset value without a write");

    a_config_read_back: assert property (
        s_cfg_write ##1 s_cfg_read |=> reg_rdata == ($past(reg_wdata, 2) & CONFIG_WR_MASK))
        else $error("configuration read-back mismatch");

    a_span12_write: assert property (
        reg_wr && reg_addr == ADDR_SPAN_12
        |=> input_span_2 == $past(reg_wdata[7:4]) && input_span_1 == $past(reg_wdata[3:0]))
        else $error("span 1/2 register write mismatch");

    a_span34_write: assert property (
        reg_wr && reg_addr == ADDR_SPAN_34
        |=> input_span_4 == $past(reg_wdata[7:4]) && input_span_3 == $past(reg_wdata[3:0]))
        else $error("span 3/4 register write mismatch");

    a_span56_write: assert property (
        reg_wr && reg_addr == ADDR_SPAN_56
        |=> input_span_6 == $past(reg_wdata[7:4]) && input_span_5 == $past(reg_wdata[3:0]))
        else $error("span 5/6 register write mismatch");

    a_span56_read: assert property (
        reg_rd && reg_addr == ADDR_SPAN_56 |=> reg_rdata == {input_span_6, input_span_5})
        else $error("span 5/6 read data mismatch");

    a_span_code_12v5: assert property (
        s_ch1_write_code(SPAN_CODE_12V5) |=> span_kind_1 == SPAN_12V5 && input_span_1 == SPAN_CODE_12V5)
        else $error("code 3 did not select 12.5 V span");

    a_span_code_2v5: assert property (
        input_span_4 == SPAN_CODE_2V5 |-> span_kind_4 == SPAN_2V5 && !span_reserved[3])
        else $error("code 0 did not select 2.5 V span");

    a_span_rsvd_flag: assert property (
        input_span_6 > SPAN_CODE_12V5 |-> span_kind_6 == SPAN_RESERVED && span_reserved[5])
        else $error("reserved code not flagged");

    a_span_reset_val: assert property (
        !span_written_q |-> input_span_1 == SPAN_CODE_RST && input_span_4 == SPAN_CODE_RST
        && input_span_6 == SPAN_CODE_RST && span_kind_3 == SPAN_10V)
        else $error("span field left code 2 without a write");

    a_rsvd_bit_zero: assert property (
        s_cfg_write ##1 s_cfg_read |=> reg_rdata[RSVD_BIT] == 1'b0 && reg_rdata[7] == 1'b0)
        else $error("reserved configuration bit read non-zero");

    a_span_rsvd_match: assert property (
        span_reserved == {span_kind_6 == SPAN_RESERVED, span_kind_5 == SPAN_RESERVED,
                          span_kind_4 == SPAN_RESERVED, span_kind_3 == SPAN_RESERVED,
                          span_kind_2 == SPAN_RESERVED, span_kind_1 == SPAN_RESERVED})
        else $error("reserved flags disagree with decoded spans");

    a_unmapped_rd_zero: assert property (
        reg_rd && (reg_addr < ADDR_CONFIG || reg_addr > ADDR_SPAN_56) |=> reg_rdata == RDATA_IDLE)
        else $error("unmapped address read non-zero");

    a_rdata_one_cycle: assert property (
        !reg_rd |=> reg_rdata == RDATA_IDLE)
        else $error("read data stood beyond its cycle");

endmodule : adc_mode_range_config

// File: acq_cfg_pkg.sv
// Constants, types and span decoding for the converter configuration bank.
// Assumes a single 250 MHz clock domain and an 8-bit register port.
package acq_cfg_pkg;

    // ********************************
    // Register map and reset values
    // ********************************
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          NUM_CH          = 6;
    localparam logic [7:0]  ADDR_CONFIG     = 8'h02;
    localparam logic [7:0]  ADDR_SPAN_12    = 8'h03;
    localparam logic [7:0]  ADDR_SPAN_34    = 8'h04;
    localparam logic [7:0]  ADDR_SPAN_56    = 8'h05;
    localparam logic [7:0]  CONFIG_RST      = 8'h00;
    localparam logic [7:0]  SPAN_PAIR_RST   = 8'h22;
    localparam logic [3:0]  SPAN_CODE_RST   = 4'h2;
    localparam logic [7:0]  RDATA_IDLE      = 8'h00;

    // ********************************
    // Configuration field layout
    // ********************************
    // Writable bits: 6 header, 5 ext os clock, 4:3 output lanes, 1:0 mode
    localparam logic [7:0]  CONFIG_WR_MASK  = 8'h7B;
    localparam int          MODE_LSB        = 0;
    localparam int          RSVD_BIT        = 2;
    localparam int          DOUT_LSB        = 3;
    localparam int          EXT_OS_BIT      = 5;
    localparam int          HEADER_BIT      = 6;
    localparam int          SPAN_LO_LSB     = 0;
    localparam int          SPAN_HI_LSB     = 4;

    // ********************************
    // Modes and span encodings
    // ********************************
    typedef enum logic [1:0] {
        MODE_NORMAL       = 2'b00,
        MODE_STANDBY      = 2'b01,
        MODE_AUTO_STANDBY = 2'b10,
        MODE_SHUTDOWN     = 2'b11
    } op_mode_t;

    typedef enum logic [2:0] {
        SPAN_2V5      = 3'b000,
        SPAN_5V       = 3'b001,
        SPAN_10V      = 3'b010,
        SPAN_12V5     = 3'b011,
        SPAN_RESERVED = 3'b100
    } span_t;

    localparam logic [3:0]  SPAN_CODE_2V5   = 4'h0;
    localparam logic [3:0]  SPAN_CODE_5V    = 4'h1;
    localparam logic [3:0]  SPAN_CODE_10V   = 4'h2;
    localparam logic [3:0]  SPAN_CODE_12V5  = 4'h3;

    // Map a 4-bit span code to the single-ended input span it selects
    function automatic span_t span_decode(input logic [3:0] code);
        span_t res;
        res = SPAN_RESERVED;
        if (code == SPAN_CODE_2V5) begin
            res = SPAN_2V5;
        end else if (code == SPAN_CODE_5V) begin
            res = SPAN_5V;
        end else if (code == SPAN_CODE_10V) begin
            res = SPAN_10V;
        end else if (code == SPAN_CODE_12V5) begin
            res = SPAN_12V5;
        end
        return res;
    endfunction : span_decode

endpackage : acq_cfg_pkg

// File: config_reg.sv
// Configuration register with operating-mode decode.
// Assumes the caller qualifies wr_en with the address decode.
`timescale 1ns/1ps
module config_reg
    import acq_cfg_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             wr_en,
    input  wire logic [7:0]       wdata,
    output logic      [7:0]       cfg_q,
    output op_mode_t              mode_q,
    output logic                  normal_q,
    output logic                  standby_q,
    output logic                  auto_standby_q,
    output logic                  shutdown_q
);

    logic     [7:0] cfg_d;
    op_mode_t       mode_d;

    // Reserved bits keep zero whatever is written
    assign cfg_d  = wr_en ? (wdata & CONFIG_WR_MASK) : cfg_q;
    assign mode_d = op_mode_t'(cfg_d[MODE_LSB +: 2]);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= CONFIG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Mode flags move on the same edge as the field
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q         <= MODE_NORMAL;
            normal_q       <= 1'b1;
            standby_q      <= 1'b0;
            auto_standby_q <= 1'b0;
            shutdown_q     <= 1'b0;
        end else begin
            mode_q         <= mode_d;
            normal_q       <= (mode_d == MODE_NORMAL);
            standby_q      <= (mode_d == MODE_STANDBY);
            auto_standby_q <= (mode_d == MODE_AUTO_STANDBY);
            shutdown_q     <= (mode_d == MODE_SHUTDOWN);
        end
    end

endmodule : config_reg

// File: span_pair_reg.sv
// One span register holding the codes of two channels, with span decode.
// Assumes the caller qualifies wr_en with the address decode.
`timescale 1ns/1ps
module span_pair_reg
    import acq_cfg_pkg::*;
#(
    parameter logic [7:0] RST_VAL = SPAN_PAIR_RST
)
(
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             wr_en,
    input  wire logic [7:0]       wdata,
    output logic      [7:0]       pair_q,
    output span_t                 lo_kind_q,
    output span_t                 hi_kind_q
);

    logic [7:0] pair_d;

    assign pair_d = wr_en ? wdata : pair_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pair_q <= RST_VAL;
        end else begin
            pair_q <= pair_d;
        end
    end

    // Decoded span tracks the stored code without lag
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lo_kind_q <= span_decode(RST_VAL[SPAN_LO_LSB +: 4]);
            hi_kind_q <= span_decode(RST_VAL[SPAN_HI_LSB +: 4]);
        end else begin
            lo_kind_q <= span_decode(pair_d[SPAN_LO_LSB +: 4]);
            hi_kind_q <= span_decode(pair_d[SPAN_HI_LSB +: 4]);
        end
    end

endmodule : span_pair_reg

// File: tb_top.sv
// Self-checking bench for the mode and span configuration bank.
// Assumes the bank's package and modules are compiled first; single 250 MHz clock.
`timescale 1ns/1ps
module tb_top;
    import acq_cfg_pkg::*;

    // ********************************
    // Signals and design instance
    // ********************************
    logic               ref_clk;
    logic               nrst;
    logic [ADDR_W-1:0]  reg_addr;
    logic [DATA_W-1:0]  reg_wdata;
    logic               reg_wr;
    logic               reg_rd;
    logic [DATA_W-1:0]  reg_rdata;
    op_mode_t           op_mode;
    logic               mode_normal;
    logic               mode_standby;
    logic               mode_auto_standby;
    logic               mode_shutdown;
    logic               status_header_en;
    logic               ext_os_clk_en;
    logic [1:0]         dout_lanes;
    logic [3:0]         span_w [6];
    span_t              kind_w [6];
    logic [NUM_CH-1:0]  span_reserved;
    logic [7:0]         mdl [2:5];
    int                 fail_count;
    int                 checked;
    int                 seed;

    adc_mode_range_config u_adc_mode_range_config (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_mode(op_mode),
        .mode_normal(mode_normal), .mode_standby(mode_standby),
        .mode_auto_standby(mode_auto_standby), .mode_shutdown(mode_shutdown),
        .status_header_en(status_header_en), .ext_os_clk_en(ext_os_clk_en),
        .dout_lanes(dout_lanes),
        .input_span_1(span_w[0]), .input_span_2(span_w[1]), .input_span_3(span_w[2]),
        .input_span_4(span_w[3]), .input_span_5(span_w[4]), .input_span_6(span_w[5]),
        .span_kind_1(kind_w[0]), .span_kind_2(kind_w[1]), .span_kind_3(kind_w[2]),
        .span_kind_4(kind_w[3]), .span_kind_5(kind_w[4]), .span_kind_6(kind_w[5]),
        .span_reserved(span_reserved)
    );

    always #2 ref_clk = ~ref_clk;

    // ********************************
    // Model, checks and bus tasks
    // ********************************
    task automatic model_reset();
        mdl[2] = 8'h00;
        for (int a = 3; a <= 5; a++) begin
            mdl[a] = 8'h22;
        end
    endtask : model_reset

    function automatic logic [7:0] model_rd(input logic [7:0] a);
        return (a >= 8'h02 && a <= 8'h05) ? mdl[a] : 8'h00;
    endfunction : model_rd

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // Called at a rising edge; the write is taken at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        if (a == 8'h02) begin
            mdl[2] = d & 8'h7B;
        end else if (a >= 8'h03 && a <= 8'h05) begin
            mdl[a] = d;
        end
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = model_rd(a);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, e);
        @(posedge ref_clk);
    endtask : rd

    task automatic check_outs();
        logic [3:0] nib;
        logic [3:0] onehot;
        #1;
        onehot = 4'h1 << mdl[2][1:0];
        check("rdata_idle", reg_rdata, 8'h00);
        check("op_mode", op_mode, mdl[2][1:0]);
        check("mode_onehot", {mode_shutdown, mode_auto_standby, mode_standby, mode_normal},
              onehot);
        check("cfg_bits", {status_header_en, ext_os_clk_en, dout_lanes},
              {mdl[2][6], mdl[2][5], mdl[2][4:3]});
        for (int i = 0; i < 6; i++) begin
            nib = (i % 2) ? mdl[3 + i / 2][7:4] : mdl[3 + i / 2][3:0];
            check("input_span", span_w[i], nib);
            check("span_kind", kind_w[i], (nib < 4) ? nib : 4);
        end
        check("span_reserved", span_reserved, 6'h00);
        @(posedge ref_clk);
    endtask : check_outs

    task automatic read_all();
        for (int a = 2; a <= 5; a++) begin
            rd(a[7:0]);
        end
    endtask : read_all

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // ********************************
    // Main sequence
    // ********************************
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        ref_clk = 1'b0;
        nrst = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fail_count = 0;
        checked = 0;
        seed = 68;
        model_reset();
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        check_outs();
        read_all();
        $display("test reset_values done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h02, m[7:0]);
            check_outs();
            rd(8'h02);
        end
        wr(8'h02, 8'hFF);
        rd(8'h02);
        wr(8'h02, 8'h04);
        rd(8'h02);
        check_outs();
        $display("test mode_field done");
        // every legal code on every channel
        for (int c = 0; c < 4; c++) begin
            for (int r = 3; r <= 5; r++) begin
                wr(r[7:0], {c[3:0], 4'(3 - c)});
                check_outs();
            end
        end
        $display("test span_codes done");
        for (int u = 0; u < 4; u++) begin
            a = (u == 0) ? 8'h00 : (u == 1) ? 8'h01 : (u == 2) ? 8'h06 : 8'hFF;
            wr(a, 8'h5A);
            rd(a);
        end
        read_all();
        $display("test unmapped done");
        for (int k = 0; k < 40; k++) begin
            a = 8'($unsigned($random(seed))) & 8'h07;
            d = 8'($unsigned($random(seed)));
            // span writes keep each nibble within the defined codes
            if (a >= 8'h03 && a <= 8'h05) begin
                d = d & 8'h33;
            end
            wr(a, d);
            rd(a);
        end
        check_outs();
        $display("test random_traffic done");
        wr(8'h04, 8'h13);
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        model_reset();
        // values after a reset in mid-run
        check_outs();
        read_all();
        $display("test mid_reset done");
        conclude();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        $display("[FAIL] watchdog expected finish seen hang");
        conclude();
    end

endmodule : tb_top
